// *** verilog/tcg_power_clock_ctrl.sv ***
// Slow clock selection, suspend-domain wake logic and supply-gated register access
//
// How it works
// - Slow clock absent bit at 0xF0 resets to 0: external clock present.
// - Absent bit set: external slow clock input treated as grounded.
// - Present: debounce, LED blink and key wake all run from external clock.
// - Absent: key wake alone uses a 32 kHz tick divided from reference.
// - Without external clock, key wake works only while main supply is good.
// - Slow clock config lives in suspend domain, reset only by trickle reset.
// - Device stretches a trickle power-on reset over all suspend logic.
// - Main supply low: no register read or write is decoded.
// - Wake inputs and wake output keep working while main supply is low.
// - Trickle only: enabled wake events pull the open-drain wake output low.
// - Wake sources: both ring indicators, keyboard, mouse, key detector, GP inputs.
// - Only GP 10-17 and 20-23 reach wake logic; GP 24 never does.
// - Main-supply GP output buffers disabled while main supply is absent.
// - Reference clock counted dead while main supply is absent.
// - Config register window follows the logical device numbering bit.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
module tcg_power_clock_ctrl
  import tcg_pkg::*;
#(
  parameter int unsigned BLINK_TICKS_P    = BLINK_TICKS,
  parameter int unsigned DEBOUNCE_TICKS_P = DEBOUNCE_TICKS,
  parameter int unsigned KEY_HOLD_TICKS_P = KEY_HOLD_TICKS
) (
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  input  wire logic              host_reset_i,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [DATA_W-1:0] s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [DATA_W-1:0]      s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  input  wire logic              slow_clock_pin_i,
  input  wire logic              ref_clock_14m_i,
  input  wire logic              main_supply_good_i,
  input  wire logic              front_panel_reset_in_n_i,
  input  wire logic              ring_indicate_1_n_i,
  input  wire logic              ring_indicate_2_n_i,
  input  wire logic              keyboard_data_pin_i,
  input  wire logic              mouse_data_pin_i,
  input  wire logic [GP_W-1:0]   gp_wake_pins_i,
  input  wire logic              gp_pin_24_i,
  output logic                   wake_event_out_n_o,
  output logic                   wake_event_oe_o,
  output logic                   irq_o,
  output logic                   front_panel_reset_o,
  output logic                   led_blink_o,
  output logic [GP_W-1:0]        gp_out_o,
  output logic [GP_W-1:0]        gp_oe_o,
  output logic                   trickle_por_o
);
  logic [7:0]        por_cnt_q;
  logic              por_q;
  logic              bus_rst;
  logic [7:0]        slow_cfg_q;
  logic [7:0]        ctrl_q;
  logic [WAKE_W-1:0] mask_q;
  logic [WAKE_W-1:0] status_q;
  logic [GP_W-1:0]   gp_en_q;
  logic [GP_W-1:0]   gp_val_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [3:0]        wstrb_q;
  logic              aw_have_q;
  logic              w_have_q;
  logic              wr_fire;
  logic              wr_en;
  tcg_reg_t          wr_sel;
  tcg_reg_t          rd_sel;
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] wr_word;
  logic [DATA_W-1:0] cfg_merge, ctrl_merge, mask_merge, gp_merge;
  tcg_wake_ev_t      ev_now;
  tcg_wake_ev_t      ev_prev_q;
  logic [WAKE_W-1:0] ev_w;
  logic [WAKE_W-1:0] clr_w;
  logic              ext_tick;
  logic              key_tick;
  logic              key_derived;
  logic              key_live;
  logic              fp_state_q;
  logic [3:0]        fp_cnt_q;
  logic [15:0]       blink_cnt_q;
  logic [3:0]        key_cnt_q;
  logic              key_done_q;
  logic              key_event_q;

  // Address decode shared by both channels; window moves with numbering bit
  function automatic tcg_reg_t reg_decode(input logic [ADDR_W-1:0] a, input logic ld);
    reg_decode = REG_NONE;
    if (a == WAKE_STATUS_ADDR) begin
      reg_decode = REG_STATUS;
    end else if (a == WAKE_MASK_ADDR) begin
      reg_decode = REG_MASK;
    end else if (a == CTRL_ADDR) begin
      reg_decode = REG_CTRL;
    end else if (a == STATE_ADDR) begin
      reg_decode = REG_STATE;
    end else if (a == GP_DRIVE_ADDR) begin
      reg_decode = REG_GP;
    end else if (a == (ld ? SLOW_CFG_ADDR_LD1 : SLOW_CFG_ADDR_LD0)) begin
      reg_decode = REG_CFG;
    end
  endfunction

  // Byte-lane merge of a write into the old word
  function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old_w,
                                                   input logic [DATA_W-1:0] new_w,
                                                   input logic [3:0]        strb);
    lane_merge = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        lane_merge[8*b +: 8] = new_w[8*b +: 8];
      end
    end
  endfunction

  // Trickle power-on reset, stretched so suspend logic sees a clean pulse
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      por_cnt_q <= 8'h00;
      por_q     <= 1'b1;
    end else if (por_q) begin
      if (por_cnt_q == 8'(POR_CYCLES - 1)) begin
        por_q <= 1'b0;
      end else begin
        por_cnt_q <= por_cnt_q + 8'h01;
      end
    end
  end
  assign trickle_por_o = por_q;
  assign bus_rst       = por_q | host_reset_i;

  // Write channel: address and data taken in either order, one write in flight
  assign wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid_o;
  assign wr_sel  = reg_decode(awaddr_q, ctrl_q[CTRL_NUMBER_BIT]);
  assign wr_en   = wr_fire & main_supply_good_i & (wr_sel != REG_NONE);
  always_ff @(posedge clock_i) begin
    if (bus_rst) begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= RESP_OKAY;
      aw_have_q       <= 1'b0;
      w_have_q        <= 1'b0;
      awaddr_q        <= '0;
      wdata_q         <= '0;
      wstrb_q         <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        awaddr_q        <= s_axi_awaddr_i;
        aw_have_q       <= 1'b1;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        wdata_q        <= s_axi_wdata_i;
        wstrb_q        <= s_axi_wstrb_i;
        w_have_q       <= 1'b1;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_q      <= 1'b0;
        w_have_q       <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_en ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o  <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
    end
  end

  // Read data mux, state bits reflect live block condition
  assign rd_sel = reg_decode(s_axi_araddr_i, ctrl_q[CTRL_NUMBER_BIT]);
  always_comb begin
    rd_word = '0;
    case (rd_sel)
      REG_STATUS: rd_word = DATA_W'(status_q);
      REG_MASK:   rd_word = DATA_W'(mask_q);
      REG_CTRL:   rd_word = DATA_W'(ctrl_q);
      REG_CFG:    rd_word = DATA_W'(slow_cfg_q);
      REG_GP:     rd_word = {4'h0, gp_val_q, 4'h0, gp_en_q};
      REG_STATE: begin
        rd_word[ST_SUPPLY_BIT]  = main_supply_good_i;
        rd_word[ST_DERIVED_BIT] = key_derived;
        rd_word[ST_FPRST_BIT]   = front_panel_reset_o;
        rd_word[ST_PIN24_BIT]   = gp_pin_24_i;
        rd_word[ST_KEYLIVE_BIT] = key_live;
      end
      default:    rd_word = '0;
    endcase
  end

  // Read channel: answer one cycle after the address is taken
  always_ff @(posedge clock_i) begin
    if (bus_rst) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= '0;
      s_axi_rresp_o   <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o  <= 1'b1;
        if (main_supply_good_i && (rd_sel != REG_NONE)) begin
          s_axi_rdata_o <= rd_word;
          s_axi_rresp_o <= RESP_OKAY;
        end else begin
          s_axi_rdata_o <= '0;
          s_axi_rresp_o <= RESP_SLVERR;
        end
      end
      if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o  <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  // Suspend-domain registers: a host reset leaves them alone
  assign wr_word    = lane_merge(32'h0000_0000, wdata_q, wstrb_q);
  assign cfg_merge  = lane_merge(DATA_W'(slow_cfg_q), wdata_q, wstrb_q);
  assign ctrl_merge = lane_merge(DATA_W'(ctrl_q), wdata_q, wstrb_q);
  assign mask_merge = lane_merge(DATA_W'(mask_q), wdata_q, wstrb_q);
  assign gp_merge   = lane_merge({4'h0, gp_val_q, 4'h0, gp_en_q}, wdata_q, wstrb_q);
  always_ff @(posedge clock_i) begin
    if (por_q) begin
      slow_cfg_q <= SLOW_CFG_RESET;
      ctrl_q     <= CTRL_RESET;
      mask_q     <= '0;
      gp_en_q    <= '0;
      gp_val_q   <= '0;
    end else if (wr_en) begin
      case (wr_sel)
        REG_CFG:  slow_cfg_q <= cfg_merge[7:0];
        REG_CTRL: ctrl_q     <= ctrl_merge[7:0];
        REG_MASK: mask_q     <= mask_merge[WAKE_W-1:0];
        REG_GP: begin
          gp_en_q  <= gp_merge[GP_W-1:0];
          gp_val_q <= gp_merge[GP_VAL_LSB +: GP_W];
        end
        default: ;
      endcase
    end
  end

  // Tick sources, external pin gated by the absent bit
  tcg_tick_source u_ticks (
    .clock_i                 (clock_i),
    .rst_i                   (por_q),
    .slow_clock_pin_i        (slow_clock_pin_i),
    .ref_clock_14m_i         (ref_clock_14m_i),
    .ext_slow_clock_absent_i (slow_cfg_q[CFG_ABSENT_BIT]),
    .main_supply_good_i      (main_supply_good_i),
    .ext_tick_o              (ext_tick),
    .key_tick_o              (key_tick),
    .key_derived_o           (key_derived),
    .key_live_o              (key_live)
  );

  // Front panel debounce on external ticks only; no substitute source exists
  always_ff @(posedge clock_i) begin
    if (por_q) begin
      fp_state_q <= 1'b1;
      fp_cnt_q   <= 4'h0;
    end else if (front_panel_reset_in_n_i == fp_state_q) begin
      fp_cnt_q <= 4'h0;
    end else if (ext_tick) begin
      if (fp_cnt_q == 4'(DEBOUNCE_TICKS_P - 1)) begin
        fp_state_q <= front_panel_reset_in_n_i;
        fp_cnt_q   <= 4'h0;
      end else begin
        fp_cnt_q <= fp_cnt_q + 4'h1;
      end
    end
  end

  // LED blink, also external ticks only
  always_ff @(posedge clock_i) begin
    if (por_q || !ctrl_q[CTRL_BLINK_BIT]) begin
      blink_cnt_q <= 16'h0000;
      led_blink_o <= 1'b0;
    end else if (ext_tick) begin
      if (blink_cnt_q == 16'(BLINK_TICKS_P - 1)) begin
        blink_cnt_q <= 16'h0000;
        led_blink_o <= ~led_blink_o;
      end else begin
        blink_cnt_q <= blink_cnt_q + 16'h0001;
      end
    end
  end

  // Specific-key detector: keyboard data held low for a run of key ticks
  always_ff @(posedge clock_i) begin
    if (por_q || keyboard_data_pin_i || !key_live) begin
      key_cnt_q   <= 4'h0;
      key_done_q  <= 1'b0;
      key_event_q <= 1'b0;
    end else begin
      key_event_q <= 1'b0;
      if (key_tick && !key_done_q) begin
        if (key_cnt_q == 4'(KEY_HOLD_TICKS_P - 1)) begin
          key_done_q  <= 1'b1;
          key_event_q <= 1'b1;
        end else begin
          key_cnt_q <= key_cnt_q + 4'h1;
        end
      end
    end
  end

  // Wake sources; GP 24 is kept out on purpose
  always_comb begin
    ev_now.ri1   = ~ring_indicate_1_n_i;
    ev_now.ri2   = ~ring_indicate_2_n_i;
    ev_now.kbd   = ~keyboard_data_pin_i;
    ev_now.mouse = ~mouse_data_pin_i;
    ev_now.key   = key_event_q;
    ev_now.gp    = ~gp_wake_pins_i;
  end
  assign ev_w  = ev_now & ~ev_prev_q;
  assign clr_w = (wr_en && wr_sel == REG_STATUS) ? wr_word[WAKE_W-1:0] : '0;

  // Edge history runs regardless of main supply
  always_ff @(posedge clock_i) begin
    if (por_q) begin
      ev_prev_q <= '0;
    end else begin
      ev_prev_q <= ev_now;
    end
  end

  // Sticky status, set beats a same-cycle write-one clear
  for (genvar i = 0; i < WAKE_W; i++) begin : g_status
    always_ff @(posedge clock_i) begin
      if (por_q) begin
        status_q[i] <= 1'b0;
      end else if (ev_w[i]) begin
        status_q[i] <= 1'b1;
      end else if (clr_w[i]) begin
        status_q[i] <= 1'b0;
      end
    end
  end

  // Outputs: wake pin pulled low while any enabled event is pending
  always_ff @(posedge clock_i) begin
    if (por_q) begin
      wake_event_out_n_o  <= 1'b0;
      wake_event_oe_o     <= 1'b0;
      irq_o               <= 1'b0;
      front_panel_reset_o <= 1'b0;
      gp_out_o            <= '0;
      gp_oe_o             <= '0;
    end else begin
      wake_event_out_n_o  <= 1'b0;
      wake_event_oe_o     <= |(status_q & mask_q);
      irq_o               <= |(status_q & mask_q);
      front_panel_reset_o <= ~fp_state_q;
      gp_out_o            <= gp_val_q;
      gp_oe_o             <= main_supply_good_i ? gp_en_q : '0;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  sequence s_rst_release;
    rst_i ##1 !rst_i;
  endsequence

  chk_por_stretch: assert property (disable iff (1'b0) s_rst_release |-> por_q [*8])
    else $error("trickle reset not stretched");
  chk_cfg_reset_val: assert property (por_q |=> slow_cfg_q == SLOW_CFG_RESET)
    else $error("slow clock config reset value wrong");
  chk_cfg_host_keep: assert property (host_reset_i && !por_q |=> $stable(slow_cfg_q))
    else $error("host reset disturbed slow clock config");
  chk_write_blocked: assert property (wr_fire && !main_supply_good_i
      |=> s_axi_bvalid_o && s_axi_bresp_o == RESP_SLVERR && $stable(slow_cfg_q))
    else $error("write decoded without main supply");
  chk_read_blocked: assert property (s_axi_arvalid_i && s_axi_arready_o && !main_supply_good_i
      |=> s_axi_rvalid_o && s_axi_rdata_o == 32'h0000_0000)
    else $error("read decoded without main supply");
  chk_wake_drive: assert property (!por_q && |(status_q & mask_q) |=> wake_event_oe_o && !wake_event_out_n_o)
    else $error("wake output not pulled low");
  chk_status_sticky: assert property (!por_q && ev_w != '0
      |=> (status_q & $past(ev_w)) == $past(ev_w))
    else $error("wake event lost");
  chk_gp_oe_off: assert property (!main_supply_good_i |=> gp_oe_o == '0)
    else $error("gp output driven without main supply");
  chk_ext_absent: assert property (slow_cfg_q[CFG_ABSENT_BIT] |=> !ext_tick)
    else $error("external tick while marked absent");
  chk_blink_off: assert property (!ctrl_q[CTRL_BLINK_BIT] |=> !led_blink_o)
    else $error("LED blinking while disabled");
endmodule

// *** verilog/tcg_pkg.sv ***
// Shared constants, register map and carrier types for the trickle clock and power gating block
package tcg_pkg;
  // Bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // Register byte addresses
  localparam logic [11:0] WAKE_STATUS_ADDR = 12'h000;
  localparam logic [11:0] WAKE_MASK_ADDR   = 12'h004;
  localparam logic [11:0] CTRL_ADDR        = 12'h008;
  localparam logic [11:0] STATE_ADDR       = 12'h00C;
  localparam logic [11:0] GP_DRIVE_ADDR    = 12'h010;
  localparam logic [11:0] POWER_CTRL_BASE  = 12'h400;
  localparam logic [11:0] RUNTIME_BASE     = 12'h800;
  localparam logic [11:0] SLOW_CFG_OFFSET  = 12'h0F0;
  localparam logic [11:0] SLOW_CFG_ADDR_LD0 = POWER_CTRL_BASE + SLOW_CFG_OFFSET;
  localparam logic [11:0] SLOW_CFG_ADDR_LD1 = RUNTIME_BASE + SLOW_CFG_OFFSET;

  // Field positions and reset values
  localparam int unsigned CFG_ABSENT_BIT  = 0;
  localparam logic [7:0]  SLOW_CFG_RESET  = 8'h00;
  localparam int unsigned CTRL_NUMBER_BIT = 0;
  localparam int unsigned CTRL_BLINK_BIT  = 1;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam int unsigned ST_SUPPLY_BIT   = 0;
  localparam int unsigned ST_DERIVED_BIT  = 1;
  localparam int unsigned ST_FPRST_BIT    = 2;
  localparam int unsigned ST_PIN24_BIT    = 3;
  localparam int unsigned ST_KEYLIVE_BIT  = 4;
  localparam int unsigned GP_VAL_LSB      = 16;
  localparam int unsigned GP_W            = 12;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned POR_TIME_NS   = 1000;
  localparam int unsigned POR_CYCLES    = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REF_HZ        = 14318000;
  localparam int unsigned SLOW_HZ       = 32768;
  localparam int unsigned REF_DIV       = (REF_HZ + SLOW_HZ / 2) / SLOW_HZ;
  localparam int unsigned DEBOUNCE_TICKS = 8;
  localparam int unsigned BLINK_TICKS    = 16384;
  localparam int unsigned KEY_HOLD_TICKS = 4;

  // Wake event carrier, ring indicator 1 in bit 0
  typedef struct packed {
    logic [GP_W-1:0] gp;
    logic            key;
    logic            mouse;
    logic            kbd;
    logic            ri2;
    logic            ri1;
  } tcg_wake_ev_t;
  localparam int unsigned WAKE_W = $bits(tcg_wake_ev_t);

  // Register select
  typedef enum logic [2:0] {
    REG_NONE, REG_STATUS, REG_MASK, REG_CTRL, REG_STATE, REG_GP, REG_CFG
  } tcg_reg_t;
endpackage

// *** verilog/tcg_tick_source.sv ***
// Slow tick sources: external pin edges, divided reference, glitch-free select for the key detector
`timescale 1ns/1ps
module tcg_tick_source
  import tcg_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic slow_clock_pin_i,
  input  wire logic ref_clock_14m_i,
  input  wire logic ext_slow_clock_absent_i,
  input  wire logic main_supply_good_i,
  output logic      ext_tick_o,
  output logic      key_tick_o,
  output logic      key_derived_o,
  output logic      key_live_o
);
  logic       slow_q;
  logic       ref_q;
  logic [8:0] div_q;
  logic       sel_q;
  logic       hold_q;
  logic       ext_edge;
  logic       ref_edge;
  logic       der_tick;

  // Absent pin reads as grounded, reference dead without main supply
  assign ext_edge = ~ext_slow_clock_absent_i & slow_clock_pin_i & ~slow_q;
  assign ref_edge = main_supply_good_i & ref_clock_14m_i & ~ref_q;
  assign der_tick = ref_edge && (div_q == 9'(REF_DIV - 1));

  // Edge history and reference divider
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      slow_q <= 1'b0;
      ref_q  <= 1'b0;
      div_q  <= 9'h000;
    end else begin
      slow_q <= slow_clock_pin_i;
      ref_q  <= ref_clock_14m_i;
      if (der_tick) begin
        div_q <= 9'h000;
      end else if (ref_edge) begin
        div_q <= div_q + 9'h001;
      end
    end
  end

  // Source change only in a quiet cycle, then one blank cycle so no runt tick escapes
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sel_q      <= 1'b0;
      hold_q     <= 1'b0;
      ext_tick_o <= 1'b0;
      key_tick_o <= 1'b0;
      key_live_o <= 1'b1;
    end else begin
      hold_q <= 1'b0;
      if ((sel_q != ext_slow_clock_absent_i) && !ext_edge && !der_tick) begin
        sel_q  <= ext_slow_clock_absent_i;
        hold_q <= 1'b1;
      end
      ext_tick_o <= ext_edge;
      key_tick_o <= !hold_q && (sel_q ? (der_tick && main_supply_good_i) : ext_edge);
      key_live_o <= sel_q ? main_supply_good_i : 1'b1;
    end
  end
  assign key_derived_o = sel_q;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  chk_switch_clean: assert property ($changed(sel_q) |-> !key_tick_o ##1 !key_tick_o)
    else $error("tick emitted around source switch");
  chk_derived_gated: assert property (sel_q && !main_supply_good_i |=> !key_tick_o)
    else $error("derived key tick without main supply");
endmodule

// *** dv/tcg_chipset_model.sv ***
// Chipset side of the wake line: pull-up on the shared open-drain wire
`timescale 1ns/1ps
module tcg_chipset_model (
  input  wire logic wake_event_out_n_i,
  input  wire logic wake_event_oe_i,
  output logic      wake_line_o
);
  // Pull-up wins unless the device drives its low data
  assign wake_line_o = wake_event_oe_i ? wake_event_out_n_i : 1'b1;
endmodule

// *** dv/trickle_clock_and_power_gating_tb_top.sv ***
// Self-checking bench for the trickle clock and power gating block
`timescale 1ns/1ps
module trickle_clock_and_power_gating_tb_top;
  import tcg_pkg::*;
  logic        clock_i, rst_i, hrst, aw_v, w_v, b_r, ar_v, r_r, slow, refc, good;
  logic        ri1_n, ri2_n, kbd, mouse, pin24, fpr_n;
  logic [3:0]  div;
  logic [11:0] aw_a, ar_a, gp;
  logic [31:0] w_d, rd;
  logic [1:0]  rsp;
  wire         aw_rdy, w_rdy, b_v, ar_rdy, r_v, wake_n, wake_oe, irq, por, line, fpr, led;
  wire [1:0]   b_resp, r_resp;
  wire [31:0]  r_d;
  wire [11:0]  gp_oe, gp_out;
  int          failures, cmp_count;

  tcg_power_clock_ctrl #(.BLINK_TICKS_P(4), .DEBOUNCE_TICKS_P(2), .KEY_HOLD_TICKS_P(2)) DUT (
    .clock_i(clock_i), .rst_i(rst_i), .host_reset_i(hrst),
    .s_axi_awaddr_i(aw_a), .s_axi_awvalid_i(aw_v), .s_axi_awready_o(aw_rdy),
    .s_axi_wdata_i(w_d), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(w_v), .s_axi_wready_o(w_rdy),
    .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_v), .s_axi_bready_i(b_r),
    .s_axi_araddr_i(ar_a), .s_axi_arvalid_i(ar_v), .s_axi_arready_o(ar_rdy),
    .s_axi_rdata_o(r_d), .s_axi_rresp_o(r_resp), .s_axi_rvalid_o(r_v), .s_axi_rready_i(r_r),
    .slow_clock_pin_i(slow), .ref_clock_14m_i(refc), .main_supply_good_i(good),
    .front_panel_reset_in_n_i(fpr_n), .ring_indicate_1_n_i(ri1_n), .ring_indicate_2_n_i(ri2_n),
    .keyboard_data_pin_i(kbd), .mouse_data_pin_i(mouse), .gp_wake_pins_i(gp), .gp_pin_24_i(pin24),
    .wake_event_out_n_o(wake_n), .wake_event_oe_o(wake_oe), .irq_o(irq),
    .front_panel_reset_o(fpr), .led_blink_o(led), .gp_out_o(gp_out), .gp_oe_o(gp_oe), .trickle_por_o(por)
  );
  tcg_chipset_model chipset (.wake_event_out_n_i(wake_n), .wake_event_oe_i(wake_oe), .wake_line_o(line));

  // Clock and idle levels at time zero
  initial begin
    {hrst, aw_v, w_v, b_r, ar_v, r_r, slow, refc, div, aw_a, ar_a, w_d} = '0;
    {rst_i, good, ri1_n, ri2_n, kbd, mouse, pin24, fpr_n, gp} = '1;
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  // Board keeps the slow clock running; reference toggles each cycle
  always @(posedge clock_i) begin
    div <= div + 4'h1;
    slow <= div[3];
    refc <= ~refc;
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // One write; both channels offered together, held until taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_i);
    aw_a <= a; w_d <= d; aw_v <= 1'b1; w_v <= 1'b1; b_r <= 1'b1;
    do begin
      @(posedge clock_i);
      if (aw_rdy) aw_v <= 1'b0;
      if (w_rdy) w_v <= 1'b0;
    end while (b_v !== 1'b1);
    rsp = b_resp;
    b_r <= 1'b0;
  endtask
  task automatic rdr(input logic [11:0] a);
    @(posedge clock_i);
    ar_a <= a; ar_v <= 1'b1; r_r <= 1'b1;
    do begin
      @(posedge clock_i);
      if (ar_rdy) ar_v <= 1'b0;
    end while (r_v !== 1'b1);
    rd = r_d;
    rsp = r_resp;
    r_r <= 1'b0;
  endtask
  // Bounded wait for the stretched trickle reset to end
  task automatic por_wait;
    for (int i = 0; i < 200 && por !== 1'b0; i++) @(posedge clock_i);
    chk("por", {31'h0, por}, 32'h0);
  endtask

  task automatic t_cfg;
    rdr(SLOW_CFG_ADDR_LD0);
    chk("cfg reset", rd, 32'h0);
    good <= 1'b0;
    wr(SLOW_CFG_ADDR_LD0, 32'h1);
    chk("low supply wr", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    rdr(SLOW_CFG_ADDR_LD0);
    chk("low supply rd", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    good <= 1'b1;
    wr(SLOW_CFG_ADDR_LD0, 32'h1);
    rdr(SLOW_CFG_ADDR_LD0);
    chk("cfg absent", rd, 32'h1);
  endtask
  task automatic t_numbering;
    wr(CTRL_ADDR, 32'h1);
    rdr(SLOW_CFG_ADDR_LD1);
    chk("cfg runtime", rd, 32'h1);
    wr(CTRL_ADDR, 32'h0);
    rdr(12'h100);
    chk("unmapped", {rd[29:0], rsp}, {30'h0, RESP_SLVERR});
  endtask
  // Wake on trickle supply only; pin 24 must leave no trace
  task automatic t_wake;
    wr(WAKE_MASK_ADDR, 32'h1FFFF);
    wr(GP_DRIVE_ADDR, 32'h0ABC_0FFF);
    @(posedge clock_i);
    good <= 1'b0;
    pin24 <= 1'b0;
    ri1_n <= 1'b0;
    repeat (4) @(posedge clock_i);
    chk("wake line", {30'h0, line, irq}, 32'h1);
    chk("gp oe", {20'h0, gp_oe}, 32'h0);
    chk("gp out", {20'h0, gp_out}, 32'hABC);
    good <= 1'b1;
    ri1_n <= 1'b1;
    pin24 <= 1'b1;
    rdr(WAKE_STATUS_ADDR);
    chk("status", rd, 32'h1);
    wr(WAKE_STATUS_ADDR, 32'h1);
    repeat (3) @(posedge clock_i);
    chk("wake idle", {31'h0, line}, 32'h1);
  endtask
  task automatic t_resets;
    @(posedge clock_i);
    hrst <= 1'b1;
    @(posedge clock_i);
    hrst <= 1'b0;
    rdr(SLOW_CFG_ADDR_LD0);
    chk("cfg kept", rd, 32'h1);
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    por_wait();
    rdr(SLOW_CFG_ADDR_LD0);
    chk("cfg cleared", rd, 32'h0);
    rdr(WAKE_MASK_ADDR);
    chk("mask cleared", rd, 32'h0);
  endtask
  // Pin ticks drive debounce, blink and key detector; blink toggles every 64 cycles
  task automatic t_slow;
    int   n;
    logic p;
    n = 0;
    wr(CTRL_ADDR, 32'h2);
    fpr_n <= 1'b0;
    kbd <= 1'b0;
    p = led;
    repeat (256) begin
      @(posedge clock_i);
      if (led !== p) n++;
      p = led;
    end
    chk("blink toggles", n, 32'h4);
    chk("fp reset", {31'h0, fpr}, 32'h1);
    rdr(STATE_ADDR);
    chk("state", rd, 32'h1D);
    rdr(WAKE_STATUS_ADDR);
    chk("key wake", rd, 32'h14);
  endtask

  task automatic close_out;
    if (failures == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Hang guard, far beyond the expected run
  initial begin
    repeat (20000) @(posedge clock_i);
    failures++;
    close_out();
  end
  initial begin
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    por_wait();
    t_cfg();
    t_numbering();
    t_wake();
    t_resets();
    t_slow();
    close_out();
  end
endmodule
